/* src/bsop_pkg.sv */
// Constants and register map of the bus-shared octal I/O port
//
// Behaviour
// - All eight areas 8-bit gives generic I/O; any 16-bit area gives data bus.
// - In 8-bit mode a direction bit of 1 makes an output, 0 an input.
// - Direction register is write-only; every read returns all ones.
// - Direction register clears on reset and hardware standby, holds in software standby.
// - Software standby reinitialises neither bus width setting nor direction register.
// - Generic output pins keep driving through software standby.
// - Port read gives data bit for outputs, pin level for inputs, both modes.
// - Output data register clears on reset and hardware standby, holds in software standby.
// - In 8-bit mode pull-up on only when direction is 0 and control is 1.
// - Pull-up control clears on reset and hardware standby, holds in software standby.
// - In 16-bit mode direction is ignored for pin drive; pins become the bidirectional data bus.
// - Pull-ups forced off in reset, hardware standby and 16-bit mode.
`default_nettype none

package bsop_pkg;
   localparam int PORT_W  = 8;
   localparam int DATA_W  = 32;
   localparam int ADDR_W  = 18;
   localparam int AREAS   = 8;

   // Printed offsets are not word aligned, so they are indices
   localparam logic [15:0] IDX_PIN_DIRECTION  = 16'hFFC5;
   localparam logic [15:0] IDX_OUTPUT_DATA    = 16'hFFC7;
   localparam logic [15:0] IDX_PULLUP_CONTROL = 16'hFFDA;
   localparam logic [ADDR_W-1:0] ADDR_PIN_DIRECTION  = {IDX_PIN_DIRECTION, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_OUTPUT_DATA    = {IDX_OUTPUT_DATA, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_PULLUP_CONTROL = {IDX_PULLUP_CONTROL, 2'h0};

   localparam logic [PORT_W-1:0] RST_PIN_DIRECTION  = 8'h00;
   localparam logic [PORT_W-1:0] RST_OUTPUT_DATA    = 8'h00;
   localparam logic [PORT_W-1:0] RST_PULLUP_CONTROL = 8'h00;
   localparam logic [PORT_W-1:0] DIRECTION_READ     = 8'hFF;
   localparam logic [PORT_W-1:0] ALL_ZERO           = 8'h00;
   localparam logic [DATA_W-1:0] READ_ZERO          = 32'h0000_0000;

   typedef enum logic [1:0] {REG_DIRECTION, REG_DATA, REG_PULLUP, REG_NONE} bsop_reg_type;
endpackage

`default_nettype wire

/* src/bsop_pin_if.sv */
// Interface between the register side and the pin logic of the port
`default_nettype none

interface bsop_pin_if;
   import bsop_pkg::*;
   logic [PORT_W-1:0] direction;
   logic [PORT_W-1:0] outputData;
   logic [PORT_W-1:0] pullupControl;
   logic              wideBus;
   logic              pullupBlock;
   logic [PORT_W-1:0] busOut;
   logic              busDrive;
   logic [PORT_W-1:0] pinLevel;
   logic [PORT_W-1:0] next_pinOut;
   logic [PORT_W-1:0] next_pinOe;
   logic [PORT_W-1:0] next_pullup;
   logic [PORT_W-1:0] portRead;

   modport regs (output direction, outputData, pullupControl, wideBus, pullupBlock,
                 busOut, busDrive, pinLevel, input next_pinOut, next_pinOe, next_pullup,
                 portRead);
   modport pins (input direction, outputData, pullupControl, wideBus, pullupBlock,
                 busOut, busDrive, pinLevel, output next_pinOut, next_pinOe, next_pullup,
                 portRead);
endinterface

`default_nettype wire

/* src/bsop_pin_mux.sv */
// Per-pin steering of drive, pull-up and read-back for the port
`default_nettype none

module bsop_pin_mux
   import bsop_pkg::*;
(
   bsop_pin_if.pins pin
);
   genvar i;

   // One slice per pin
   generate
      for (i = 0; i < PORT_W; i++)
      begin : gSlice
         always_comb
         begin
            if (pin.wideBus)
            begin
               // Bus controller owns the pin; direction bits do not matter
               pin.next_pinOut[i] = pin.busOut[i];
               pin.next_pinOe[i]  = pin.busDrive;
            end
            else
            begin
               pin.next_pinOut[i] = pin.outputData[i];
               pin.next_pinOe[i]  = pin.direction[i];
            end
            // Pull-up needs input direction and its control bit
            pin.next_pullup[i] = !pin.pullupBlock && !pin.wideBus
                                 && !pin.direction[i] && pin.pullupControl[i];
            // Read-back picks latch for outputs, live level for inputs
            pin.portRead[i] = pin.direction[i] ? pin.outputData[i] : pin.pinLevel[i];
         end
      end
   endgenerate
endmodule

`default_nettype wire

/* src/bsop_port.sv */
// Bus-shared octal I/O port with APB register access
`default_nettype none

module bsop_port
   import bsop_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              clockEnable,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   input  wire logic [3:0]        pstrb,
   output var  logic              pready,
   output var  logic [DATA_W-1:0] prdata,
   output var  logic              pslverr,
   input  wire logic [AREAS-1:0]  busWidthControl,
   input  wire logic              hardwareStandby,
   input  wire logic              softwareStandby,
   input  wire logic [PORT_W-1:0] extDataOut,
   input  wire logic              extDataDrive,
   output var  logic [PORT_W-1:0] extDataIn,
   input  wire logic [PORT_W-1:0] pinIn,
   output var  logic [PORT_W-1:0] pinOut,
   output var  logic [PORT_W-1:0] pinOe,
   output var  logic [PORT_W-1:0] pullupOn
);
   bsop_pin_if pin ();

   logic [PORT_W-1:0] direction;
   logic [PORT_W-1:0] outputData;
   logic [PORT_W-1:0] pullupControl;
   logic [PORT_W-1:0] next_direction;
   logic [PORT_W-1:0] next_outputData;
   logic [PORT_W-1:0] next_pullupControl;
   logic              next_pready;
   logic [DATA_W-1:0] next_prdata;
   logic              next_pslverr;
   logic              setupPhase;
   logic              writeTaken;
   bsop_reg_type      hitReg;

   // Address decode shared by read and write paths
   function automatic bsop_reg_type decodeReg(input logic [ADDR_W-1:0] addr);
      if (addr == ADDR_PIN_DIRECTION)
         return REG_DIRECTION;
      else if (addr == ADDR_OUTPUT_DATA)
         return REG_DATA;
      else if (addr == ADDR_PULLUP_CONTROL)
         return REG_PULLUP;
      else
         return REG_NONE;
   endfunction

   assign hitReg     = decodeReg(paddr);
   assign setupPhase = psel && !penable && !pready;
   // Write lands on the single edge where the master sees pready
   assign writeTaken = psel && penable && pready && pwrite && pstrb[0];

   // Pin logic inputs; any 16-bit area switches the whole port to the bus
   assign pin.direction     = direction;
   assign pin.outputData    = outputData;
   assign pin.pullupControl = pullupControl;
   assign pin.wideBus       = |busWidthControl;
   assign pin.pullupBlock   = hardwareStandby;
   assign pin.busOut        = extDataOut;
   assign pin.busDrive      = extDataDrive;
   assign pin.pinLevel      = pinIn;

   bsop_pin_mux uMux (
      .pin (pin.pins)
   );

   // Register next values
   always_comb
   begin
      next_direction     = direction;
      next_outputData    = outputData;
      next_pullupControl = pullupControl;
      if (hardwareStandby)
      begin
         // Hardware standby reinitialises, software standby does not
         next_direction     = RST_PIN_DIRECTION;
         next_outputData    = RST_OUTPUT_DATA;
         next_pullupControl = RST_PULLUP_CONTROL;
      end
      else if (writeTaken)
      begin
         unique case (hitReg)
            REG_DIRECTION: next_direction     = pwdata[PORT_W-1:0];
            REG_DATA:      next_outputData    = pwdata[PORT_W-1:0];
            REG_PULLUP:    next_pullupControl = pwdata[PORT_W-1:0];
            REG_NONE:      next_direction     = direction;
         endcase
      end
   end

   // Registers; software standby leaves them untouched
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         direction     <= RST_PIN_DIRECTION;
         outputData    <= RST_OUTPUT_DATA;
         pullupControl <= RST_PULLUP_CONTROL;
      end
      else if (clockEnable)
      begin
         direction     <= next_direction;
         outputData    <= next_outputData;
         pullupControl <= next_pullupControl;
      end
   end

   // APB answer, prepared in setup so pready comes from a flop
   always_comb
   begin
      next_pready  = setupPhase;
      next_prdata  = prdata;
      next_pslverr = pslverr;
      if (setupPhase)
      begin
         next_pslverr = (hitReg == REG_NONE);
         next_prdata  = READ_ZERO;
         if (!pwrite)
         begin
            unique case (hitReg)
               REG_DIRECTION: next_prdata[PORT_W-1:0] = DIRECTION_READ;
               REG_DATA:      next_prdata[PORT_W-1:0] = pin.portRead;
               REG_PULLUP:    next_prdata[PORT_W-1:0] = pullupControl;
               REG_NONE:      next_prdata[PORT_W-1:0] = ALL_ZERO;
            endcase
         end
      end
      else if (pready)
      begin
         next_pslverr = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready  <= 1'b0;
         prdata  <= READ_ZERO;
         pslverr <= 1'b0;
      end
      else if (clockEnable)
      begin
         pready  <= next_pready;
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // Pin drive; hardware standby floats every pin and kills pull-ups.
   // Software standby changes nothing here, so outputs keep driving.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pinOut    <= ALL_ZERO;
         pinOe     <= ALL_ZERO;
         pullupOn  <= ALL_ZERO;
         extDataIn <= ALL_ZERO;
      end
      else if (clockEnable)
      begin
         pinOut    <= pin.next_pinOut;
         pinOe     <= hardwareStandby ? ALL_ZERO : pin.next_pinOe;
         pullupOn  <= pin.next_pullup;
         extDataIn <= pinIn;
      end
   end
endmodule

`default_nettype wire

/* src/unused_placeholder_none.sv */
// Intentionally empty file holding no design code
`default_nettype none
`default_nettype wire

/* verification/bsop_pin_model.sv */
// External pins: port drive, a test load, pull-ups and floating lines
`default_nettype none
module bsop_pin_model
   import bsop_pkg::*;
(
   input  wire logic              clock,
   input  wire logic [PORT_W-1:0] pinOut,
   input  wire logic [PORT_W-1:0] pinOe,
   input  wire logic [PORT_W-1:0] pullupOn,
   input  wire logic [PORT_W-1:0] loadOn,
   input  wire logic [PORT_W-1:0] loadLevel,
   output var  logic [PORT_W-1:0] pinIn
);
   logic [PORT_W-1:0] drift = 8'h55;
   // Floating lines toggle so a stale level never reads as good
   always @(posedge clock) drift <= ~drift;
   // Port drive wins over the load; pull-up only on an open line
   always_comb pinIn = (pinOe & pinOut) | (~pinOe & loadOn & loadLevel)
                     | (~pinOe & ~loadOn & (pullupOn | drift));
endmodule
`default_nettype wire

/* verification/bsop_port_props.sv */
// Concurrent checks on the pins and register reads of the port
`default_nettype none
module bsop_port_props
   import bsop_pkg::*;
(
   input wire logic              clock,
   input wire logic              rst_n,
   input wire logic              clockEnable,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic              pready,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic [AREAS-1:0]  busWidthControl,
   input wire logic              hardwareStandby,
   input wire logic [PORT_W-1:0] extDataOut,
   input wire logic              extDataDrive,
   input wire logic [PORT_W-1:0] extDataIn,
   input wire logic [PORT_W-1:0] pinIn,
   input wire logic [PORT_W-1:0] pinOut,
   input wire logic [PORT_W-1:0] pinOe,
   input wire logic [PORT_W-1:0] pullupOn
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Pin relations; mode changes land one edge later
   a_pullup_input_only: assert property ((pullupOn & pinOe) == ALL_ZERO)
      else $error("pull-up on a driving pin");
   a_wide_no_pullup: assert property (clockEnable && busWidthControl != '0
      |=> pullupOn == ALL_ZERO) else $error("pull-up on in wide mode");
   a_standby_floats: assert property (clockEnable && hardwareStandby
      |=> pinOe == ALL_ZERO && pullupOn == ALL_ZERO) else $error("pins active in standby");
   a_wide_bus_drive: assert property (clockEnable && !hardwareStandby && busWidthControl != '0
      |=> pinOe == {PORT_W{$past(extDataDrive)}} && pinOut == $past(extDataOut))
      else $error("data bus not steered");
   a_standby_clears: assert property (clockEnable && hardwareStandby ##1 clockEnable
      && !hardwareStandby && busWidthControl == '0 |=> pinOe == ALL_ZERO && pinOut == ALL_ZERO)
      else $error("registers kept after standby");
   a_dir_reads_ones: assert property (clockEnable && psel && !penable && !pwrite
      && paddr == ADDR_PIN_DIRECTION |=> pready && prdata[PORT_W-1:0] == DIRECTION_READ)
      else $error("direction read not all ones");
   a_dir_drives_oe: assert property (psel && penable && pready && pwrite && pstrb[0]
      && paddr == ADDR_PIN_DIRECTION && clockEnable && !hardwareStandby ##1 clockEnable
      && !hardwareStandby && busWidthControl == '0 |=> pinOe == $past(pwdata[7:0], 2))
      else $error("direction write not on enables");
   // The edge that releases reset still sees the flop in reset
   a_bus_read_copy: assert property (clockEnable && !hardwareStandby
      |=> extDataIn == ($past(rst_n) ? $past(pinIn) : ALL_ZERO))
      else $error("bus input not copied");
endmodule
bind bsop_port bsop_port_props u_props (.clock, .rst_n, .clockEnable, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .busWidthControl, .hardwareStandby,
   .extDataOut, .extDataDrive, .extDataIn, .pinIn, .pinOut, .pinOe, .pullupOn);
`default_nettype wire

/* verification/bsop_port_tb.sv */
// Self-checking bench for the bus-shared octal port
`default_nettype none
module bsop_port_tb
   import bsop_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0, rst_n = 1'b0, clockEnable = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, extDataDrive = 1'b0;
   logic hardwareStandby = 1'b0, softwareStandby = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata, rd;
   logic [3:0]        pstrb = 4'hF;
   logic [AREAS-1:0]  busWidthControl = 8'h00;
   logic [PORT_W-1:0] extDataOut = 8'h00, extDataIn, pinIn, pinOut, pinOe, pullupOn;
   logic [PORT_W-1:0] loadOn = 8'hFF, loadLevel = 8'hA5;
   logic              err;
   // Word between two mapped registers, decoded by nothing
   localparam logic [ADDR_W-1:0] ADDR_UNMAPPED = ADDR_OUTPUT_DATA - 18'h00004;
   int                n_mismatch = 0, tests_run = 0;

   bsop_port u_dut (.clock, .rst_n, .clockEnable, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .pready, .prdata, .pslverr, .busWidthControl, .hardwareStandby,
      .softwareStandby, .extDataOut, .extDataDrive, .extDataIn, .pinIn, .pinOut, .pinOe,
      .pullupOn);
   bsop_pin_model u_pins (.clock, .pinOut, .pinOe, .pullupOn, .loadOn, .loadLevel, .pinIn);

   // 40 MHz clock
   always #12.5 clock = ~clock;

   task automatic print_verdict;
      $display("Counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         n_mismatch++;
         print_verdict();
      end
   endtask

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(e, rd[7:0]);
   endtask

   // Main sequence
   initial
   begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      rdchk(ADDR_PIN_DIRECTION, 8'hFF);
      rdchk(ADDR_PULLUP_CONTROL, 8'h00);
      rdchk(ADDR_OUTPUT_DATA, 8'hA5);
      chk(8'h00, pinOe);
      chk(8'h00, pinOut);
      $display("test reset done");
      apb(1'b1, ADDR_PIN_DIRECTION, 8'hF0);
      apb(1'b1, ADDR_OUTPUT_DATA, 8'h3C);
      apb(1'b1, ADDR_PULLUP_CONTROL, 8'hFF);
      pstrb <= 4'h0;
      apb(1'b1, ADDR_OUTPUT_DATA, 8'hFF);
      pstrb <= 4'hF;
      repeat (3) @(posedge clock);
      chk(8'hF0, pinOe);
      chk(8'h3C, pinOut);
      chk(8'h0F, pullupOn);
      rdchk(ADDR_OUTPUT_DATA, 8'h35);
      rdchk(ADDR_PIN_DIRECTION, 8'hFF);
      $display("test generic io done");
      softwareStandby <= 1'b1;
      repeat (5) @(posedge clock);
      chk(8'hF0, pinOe);
      chk(8'h3C, pinOut);
      chk(8'h0F, pullupOn);
      rdchk(ADDR_OUTPUT_DATA, 8'h35);
      softwareStandby <= 1'b0;
      $display("test software standby done");
      extDataOut <= 8'h5A;
      extDataDrive <= 1'b1;
      // Each area alone selects the wide bus
      for (int i = 0; i < AREAS; i++)
      begin
         busWidthControl <= 8'h01 << i;
         repeat (2) @(posedge clock);
         chk(8'hFF, pinOe);
         chk(8'h00, pullupOn);
      end
      chk(8'h5A, pinOut);
      rdchk(ADDR_OUTPUT_DATA, 8'h3A);
      chk(8'h5A, extDataIn);
      extDataDrive <= 1'b0;
      repeat (3) @(posedge clock);
      chk(8'h00, pinOe);
      chk(8'hA5, extDataIn);
      $display("test wide bus done");
      busWidthControl <= 8'h00;
      hardwareStandby <= 1'b1;
      repeat (3) @(posedge clock);
      chk(8'h00, pinOe);
      chk(8'h00, pullupOn);
      hardwareStandby <= 1'b0;
      repeat (2) @(posedge clock);
      rdchk(ADDR_PULLUP_CONTROL, 8'h00);
      rdchk(ADDR_OUTPUT_DATA, 8'hA5);
      chk(8'h00, pinOut);
      $display("test hardware standby done");
      // Unmapped word answers with an error and changes nothing
      apb(1'b1, ADDR_UNMAPPED, 8'hFF);
      chk(8'h01, {7'h00, err});
      rdchk(ADDR_UNMAPPED, 8'h00);
      chk(8'h01, {7'h00, err});
      rdchk(ADDR_PULLUP_CONTROL, 8'h00);
      chk(8'h00, {7'h00, err});
      chk(8'h00, pinOe);
      chk(8'h00, pinOut);
      $display("test unmapped address done");
      apb(1'b1, ADDR_PIN_DIRECTION, 8'h0F);
      apb(1'b1, ADDR_PULLUP_CONTROL, 8'hF0);
      apb(1'b1, ADDR_OUTPUT_DATA, 8'hC3);
      repeat (2) @(posedge clock);
      chk(8'h0F, pinOe);
      chk(8'hC3, pinOut);
      chk(8'hF0, pullupOn);
      // Low clock enable freezes the pins, mode change included
      clockEnable <= 1'b0;
      busWidthControl <= 8'h80;
      repeat (3) @(posedge clock);
      chk(8'h0F, pinOe);
      chk(8'hF0, pullupOn);
      clockEnable <= 1'b1;
      repeat (2) @(posedge clock);
      chk(8'h00, pinOe);
      chk(8'h00, pullupOn);
      $display("test clock enable done");
      // System reset in mid-run clears all three registers
      busWidthControl <= 8'h00;
      rst_n <= 1'b0;
      repeat (3) @(posedge clock);
      chk(8'h00, pullupOn);
      rst_n <= 1'b1;
      rdchk(ADDR_PULLUP_CONTROL, 8'h00);
      rdchk(ADDR_OUTPUT_DATA, 8'hA5);
      chk(8'h00, pinOe);
      chk(8'h00, pinOut);
      chk(8'h00, pullupOn);
      $display("test mid-run reset done");
      print_verdict();
   end
endmodule
`default_nettype wire
